// *** src/pmm_map.sv ***
/*
 * Program counter and banked data memory map of the core.
 * The program side advances, jumps and vectors a 13-bit counter and
 * masks the fetch address to the implemented depth. The data side turns
 * a direct or indirect offset into a bank address, serves the core
 * registers from flops in every bank, reads the other special offsets as zero and serves the rest from a RAM.
 * Assumes the core sequencer drives requests synchronous to clk_sys,
 * and that software writes each RAM cell before reading it, since the
 * array has no reset.
 */
`timescale 1ns/10ps
`include "pmm_params.svh"

module pmm_map #(
    parameter int PROG_AW = `PMM_PROG_AW_LARGE
) (
    input  wire logic                   clk_sys,
    input  wire logic                   rstn,
    input  wire pmm_pkg::pmm_prog_req_t prog_req,
    input  wire pmm_pkg::pmm_data_req_t data_req,
    output logic [`PMM_PC_W-1:0]        pc,
    output logic [`PMM_PC_W-1:0]        prog_addr,
    output logic                        prog_valid,
    output logic [`PMM_DATA_W-1:0]      data_rdata,
    output logic                        data_rvalid,
    output logic [`PMM_DATA_W-1:0]      status,
    output logic [`PMM_DATA_W-1:0]      indirect_pointer,
    output logic [1:0]                  bank
);
    import pmm_pkg::*;

    localparam logic [`PMM_PC_W-1:0] WRAP_MASK = `PMM_PC_W'((1 << PROG_AW) - 1);

    pmm_state_t state_reg;
    pmm_state_t state_next;

    logic                      bank_select_high;
    logic                      bank_select_low;
    logic                      via_pointer;
    logic [`PMM_BANK_AW-1:0]   ofs;
    logic [`PMM_FULL_AW-1:0]   full_addr;
    logic                      is_sfr;
    logic                      is_common;
    logic                      ram_hit;
    logic                      ram_wr;
    logic [`PMM_FULL_AW-1:0]   ram_addr;
    logic [`PMM_DATA_W-1:0]    ram_rdata;
    logic [`PMM_DATA_W-1:0]    sfr_rdata;
    logic [`PMM_PC_W-1:0]      pc_step;

    // Write strobes, next counter value and held register read data
    logic                      wr_sfr;
    logic                      wr_pcl;
    logic                      wr_status;
    logic                      wr_pointer;
    logic                      wr_pclath;
    logic                      wr_intctl;
    logic [`PMM_PC_W-1:0]      pc_target;
    logic [`PMM_PC_W-1:0]      pcl_target;
    logic [`PMM_DATA_W-1:0]    rd_hold;

    assign bank_select_high = state_reg.status[`PMM_BSEL_HI_BIT];
    assign bank_select_low  = state_reg.status[`PMM_BSEL_LO_BIT];

    // Offset 00h is not a register: it redirects through the pointer
    assign via_pointer = (data_req.addr == `PMM_OFS_INDIRECT);

    always_comb begin
        if (via_pointer) begin
            // Pointer bit 7 stands in for the low bank bit, high bit from status
            full_addr = {bank_select_high, state_reg.pointer};
        end else begin
            full_addr = {bank_select_high, bank_select_low, data_req.addr};
        end
    end

    assign ofs       = full_addr[`PMM_BANK_AW-1:0];
    assign is_sfr    = (ofs < `PMM_SFR_LIMIT);
    assign is_common = (ofs >= `PMM_COMMON_BASE);
    // Common top region aliases bank 0 so it is reachable from any bank
    assign ram_addr  = is_common ? {2'b00, ofs} : full_addr;
    // A pointer access to offset 00h itself would loop; treat it as no location
    assign ram_hit   = !is_sfr && !(via_pointer && state_reg.pointer[`PMM_BANK_AW-1:0] == `PMM_OFS_INDIRECT);
    assign ram_wr    = data_req.wr_en && ram_hit;

    pmm_ram #(
        .AW    (`PMM_FULL_AW),
        .DW    (`PMM_DATA_W),
        .WORDS (`PMM_RAM_WORDS)
    ) u_ram (
        .clk_sys (clk_sys),
        .wr_en   (ram_wr),
        .addr    (ram_addr),
        .wdata   (data_req.wdata),
        .rdata   (ram_rdata)
    );

    // Core registers are the same physical flops in every bank
    always_comb begin
        case (ofs)
            `PMM_OFS_PCL:     sfr_rdata = state_reg.pc[`PMM_DATA_W-1:0];
            `PMM_OFS_STATUS:  sfr_rdata = state_reg.status;
            `PMM_OFS_POINTER: sfr_rdata = state_reg.pointer;
            `PMM_OFS_PCLATH:  sfr_rdata = state_reg.pclath;
            `PMM_OFS_INTCTL:  sfr_rdata = state_reg.intctl;
            default:          sfr_rdata = '0;
        endcase
    end

    assign wr_sfr     = data_req.wr_en && is_sfr;
    assign pc_step    = `PMM_PC_W'(state_reg.pc + 1'b1);
    // Upper counter bits come from the latch register, as a computed jump needs
    assign pcl_target = {state_reg.pclath[`PMM_PC_W-`PMM_DATA_W-1:0], data_req.wdata};

    // One strobe per core register keeps the write decode apart from the state update
    always_comb begin
        wr_pcl     = 1'b0;
        wr_status  = 1'b0;
        wr_pointer = 1'b0;
        wr_pclath  = 1'b0;
        wr_intctl  = 1'b0;
        if (wr_sfr) begin
            case (ofs)
                `PMM_OFS_PCL:     wr_pcl     = 1'b1;
                `PMM_OFS_STATUS:  wr_status  = 1'b1;
                `PMM_OFS_POINTER: wr_pointer = 1'b1;
                `PMM_OFS_PCLATH:  wr_pclath  = 1'b1;
                `PMM_OFS_INTCTL:  wr_intctl  = 1'b1;
                // Unbuilt special locations take no write
                default:          wr_pcl     = 1'b0;
            endcase
        end
    end

    // A data write to the low counter byte overrides every program request
    always_comb begin
        if (wr_pcl) begin
            pc_target = pcl_target;
        end else if (prog_req.int_take) begin
            pc_target = `PMM_INT_VEC;
        end else if (prog_req.jump) begin
            pc_target = prog_req.jump_addr;
        end else if (prog_req.fetch_en) begin
            pc_target = pc_step;
        end else begin
            pc_target = state_reg.pc;
        end
    end

    // RAM data come later from the memory's own output register, so only registers are held here
    always_comb begin
        if (ram_hit) begin
            rd_hold = '0;
        end else if (is_sfr) begin
            rd_hold = sfr_rdata;
        end else begin
            rd_hold = '0;
        end
    end

    always_comb begin
        state_next        = state_reg;
        state_next.rvalid = data_req.rd_en;
        state_next.mode   = data_req.rd_en ? PMM_HOLD : PMM_RUN;
        if (data_req.rd_en) begin
            state_next.sel_ram = ram_hit;
            state_next.rdata   = rd_hold;
        end
        if (wr_status) begin
            state_next.status = data_req.wdata;
        end
        if (wr_pointer) begin
            state_next.pointer = data_req.wdata;
        end
        if (wr_pclath) begin
            state_next.pclath = data_req.wdata;
        end
        if (wr_intctl) begin
            state_next.intctl = data_req.wdata;
        end
        state_next.pc        = pc_target;
        // Fetch address is masked to the implemented depth; the counter keeps all 13 bits
        state_next.prog_addr = pc_target & WRAP_MASK;
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state_reg           <= '0;
            state_reg.pc        <= `PMM_RESET_VEC;
            state_reg.prog_addr <= `PMM_RESET_VEC;
            state_reg.status    <= `PMM_STATUS_RST;
            state_reg.mode      <= PMM_RUN;
        end else begin
            state_reg <= state_next;
        end
    end

    // Program port follows its own requests, except that a data write to the low counter byte loads the counter
    assign pc               = state_reg.pc;
    assign prog_addr        = state_reg.prog_addr;
    assign prog_valid       = rstn;
    assign data_rdata       = state_reg.sel_ram ? ram_rdata : state_reg.rdata;
    assign data_rvalid      = state_reg.rvalid;
    assign status           = state_reg.status;
    assign indirect_pointer = state_reg.pointer;
    assign bank             = {bank_select_high, bank_select_low};
endmodule : pmm_map

// *** common/pmm_params.svh ***
/*
 * Constants for the program and data memory map of the core.
 * Assumes inclusion by bare name from the package and the design files.
 */
`ifndef PMM_PARAMS_SVH
`define PMM_PARAMS_SVH

`define PMM_PC_W          13
`define PMM_INSTR_W       14
`define PMM_PROG_AW_LARGE 13
`define PMM_PROG_AW_SMALL 12
`define PMM_RESET_VEC     13'h0000
`define PMM_INT_VEC       13'h0004
`define PMM_DATA_W        8
`define PMM_BANK_AW       7
`define PMM_FULL_AW       9
`define PMM_BSEL_HI_BIT   6
`define PMM_BSEL_LO_BIT   5
`define PMM_STATUS_RST    8'h18
`define PMM_SFR_LIMIT     7'h20
`define PMM_COMMON_BASE   7'h70
`define PMM_OFS_INDIRECT  7'h00
`define PMM_OFS_PCL       7'h02
`define PMM_OFS_STATUS    7'h03
`define PMM_OFS_POINTER   7'h04
`define PMM_OFS_PCLATH    7'h0a
`define PMM_OFS_INTCTL    7'h0b
`define PMM_RAM_WORDS     512

`endif

// *** common/pmm_pkg.sv ***
/*
 * Types for the memory map block.
 * Assumes pmm_params.svh is on the include path.
 */
`include "pmm_params.svh"

package pmm_pkg;

    typedef struct packed {
        logic                    fetch_en;
        logic                    jump;
        logic [`PMM_PC_W-1:0]    jump_addr;
        logic                    int_take;
    } pmm_prog_req_t;

    typedef struct packed {
        logic                     rd_en;
        logic                     wr_en;
        logic [`PMM_BANK_AW-1:0]  addr;
        logic [`PMM_DATA_W-1:0]   wdata;
    } pmm_data_req_t;

    typedef enum logic [1:0] {
        PMM_RUN,
        PMM_HOLD
    } pmm_mode_t;

    typedef struct packed {
        logic [`PMM_PC_W-1:0]     pc;
        logic [`PMM_PC_W-1:0]     prog_addr;
        logic [`PMM_DATA_W-1:0]   status;
        logic [`PMM_DATA_W-1:0]   pointer;
        logic [`PMM_DATA_W-1:0]   pclath;
        logic [`PMM_DATA_W-1:0]   intctl;
        logic [`PMM_DATA_W-1:0]   rdata;
        logic                     rvalid;
        logic                     sel_ram;
        pmm_mode_t                mode;
    } pmm_state_t;

endpackage : pmm_pkg

// *** src/pmm_ram.sv ***
/*
 * General purpose static RAM for the data memory, registered read port.
 * Assumes one clock; read data appear one cycle after the request.
 */
`timescale 1ns/10ps
`include "pmm_params.svh"

module pmm_ram #(
    parameter int AW    = `PMM_FULL_AW,
    parameter int DW    = `PMM_DATA_W,
    parameter int WORDS = `PMM_RAM_WORDS
) (
    input  wire logic          clk_sys,
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] addr,
    input  wire logic [DW-1:0] wdata,
    output logic      [DW-1:0] rdata
);
    logic [DW-1:0] mem [WORDS];

    // No reset on the array; only the read register matters after reset
    always_ff @(posedge clk_sys) begin
        if (wr_en) begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end
endmodule : pmm_ram

// *** sim/pmm_map_chk.sv ***
/* Port assertions for pmm_map.
   Assumes pmm_pkg and pmm_params.svh are compiled first. */
`timescale 1ns/10ps
`include "pmm_params.svh"
module pmm_map_chk #(parameter int PROG_AW = `PMM_PROG_AW_LARGE) (
    input wire logic                   clk_sys,
    input wire logic                   rstn,
    input wire pmm_pkg::pmm_prog_req_t prog_req,
    input wire pmm_pkg::pmm_data_req_t data_req,
    input wire logic [12:0]            pc,
    input wire logic [12:0]            prog_addr,
    input wire logic [7:0]             data_rdata,
    input wire logic                   data_rvalid,
    input wire logic [7:0]             status,
    input wire logic [7:0]             indirect_pointer,
    input wire logic [1:0]             bank
);
    import pmm_pkg::*;
    localparam logic [12:0] MASK = (13'h0001 << PROG_AW) - 13'h0001;
    wire quiet = !data_req.wr_en && !prog_req.int_take;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    sequence s_hole_rd; data_req.rd_en && data_req.addr == 7'h01; endsequence
    property p_bank; bank == status[6:5]; endproperty
    property p_int; prog_req.int_take && !data_req.wr_en |=> pc == 13'h0004; endproperty
    property p_fetch; prog_req.fetch_en && !prog_req.jump && quiet |=> pc == $past(pc) + 13'h0001; endproperty
    property p_jump; prog_req.jump && quiet |=> pc == $past(prog_req.jump_addr); endproperty
    property p_wrap; prog_addr == (pc & MASK); endproperty
    property p_rvalid; data_req.rd_en |=> data_rvalid; endproperty
    property p_norv; !data_req.rd_en |=> !data_rvalid; endproperty
    property p_hole; s_hole_rd |=> data_rdata == 8'h00; endproperty
    property p_ptr; data_req.wr_en && data_req.addr == 7'h04 |=> indirect_pointer == $past(data_req.wdata); endproperty
    a_bank: assert property (p_bank) else $error("bank differs from status");
    a_int: assert property (p_int) else $error("interrupt vector missed");
    a_fetch: assert property (p_fetch) else $error("fetch did not advance");
    a_jump: assert property (p_jump) else $error("jump target missed");
    a_wrap: assert property (p_wrap) else $error("fetch address not wrapped");
    a_rvalid: assert property (p_rvalid) else $error("read not answered");
    a_norv: assert property (p_norv) else $error("spurious read valid");
    a_hole: assert property (p_hole) else $error("hole read nonzero");
    a_ptr: assert property (p_ptr) else $error("pointer not written");
endmodule : pmm_map_chk

bind pmm_map pmm_map_chk #(.PROG_AW(PROG_AW)) u_chk (.clk_sys(clk_sys), .rstn(rstn),
    .prog_req(prog_req), .data_req(data_req), .pc(pc), .prog_addr(prog_addr), .data_rdata(data_rdata),
    .data_rvalid(data_rvalid), .status(status), .indirect_pointer(indirect_pointer), .bank(bank));

// *** sim/pmm_map_tb.sv ***
/* Self-checking bench for pmm_map in its 4K program variant, with an 8K copy on the same stimulus.
   Assumes pmm_pkg, the header and the checker are compiled first. */
`timescale 1ns/10ps
`include "pmm_params.svh"
module pmm_map_tb;
    import pmm_pkg::*;
    logic          clk_sys = 1'b0;
    logic          rstn = 1'b0;
    pmm_prog_req_t pr = '0;
    pmm_data_req_t dr = '0;
    logic [12:0]   pc;
    logic [12:0]   prog_addr;
    logic [12:0]   prog_addr_8k;
    logic [7:0]    data_rdata;
    logic [7:0]    status;
    logic [7:0]    indirect_pointer;
    logic          prog_valid;
    logic          data_rvalid;
    logic [1:0]    bank;
    int            err_count = 0;
    int            n_compared = 0;
    pmm_map #(.PROG_AW(12)) dut (.clk_sys(clk_sys), .rstn(rstn), .prog_req(pr), .data_req(dr), .pc(pc),
        .prog_addr(prog_addr), .prog_valid(prog_valid), .data_rdata(data_rdata), .data_rvalid(data_rvalid),
        .status(status), .indirect_pointer(indirect_pointer), .bank(bank));
    // Full-depth variant: its fetch address must follow the counter with no wrap
    pmm_map #(.PROG_AW(13)) dut_8k (.clk_sys(clk_sys), .rstn(rstn), .prog_req(pr), .data_req(dr), .pc(),
        .prog_addr(prog_addr_8k), .prog_valid(), .data_rdata(), .data_rvalid(), .status(), .indirect_pointer(),
        .bank());
    task automatic chk(input string nm, input logic [12:0] exp, input logic [12:0] got);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        dr.wr_en = 1'b1;
        dr.addr = a;
        dr.wdata = d;
        @(negedge clk_sys);
        dr.wr_en = 1'b0;
        // Idle edge so a following call never re-raises a strobe in the same step
        @(negedge clk_sys);
    endtask : wr
    // Read data stand one cycle, so they are judged at the very next falling edge
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        dr.rd_en = 1'b1;
        dr.addr = a;
        @(negedge clk_sys);
        dr.rd_en = 1'b0;
        chk("data_rvalid", 13'h0001, {12'h000, data_rvalid});
        chk("data_rdata", {5'h00, e}, {5'h00, data_rdata});
        @(negedge clk_sys);
    endtask : rd
    task automatic t_reset;
        chk("pc", 13'h0000, pc);
        chk("status", 13'h0018, {5'h00, status});
        chk("bank", 13'h0000, {11'h000, bank});
        chk("prog_valid", 13'h0001, {12'h000, prog_valid});
    endtask : t_reset
    // Fetch stays high through jump and interrupt to exercise priority
    task automatic t_prog;
        pr.fetch_en = 1'b1;
        repeat (3) @(negedge clk_sys);
        chk("pc", 13'h0003, pc);
        pr.jump = 1'b1;
        pr.jump_addr = 13'h1ffe;
        @(negedge clk_sys);
        pr.jump = 1'b0;
        chk("prog_addr", 13'h0ffe, prog_addr);
        repeat (2) @(negedge clk_sys);
        chk("pc", 13'h0000, pc);
        pr.int_take = 1'b1;
        @(negedge clk_sys);
        pr = '0;
        chk("pc", 13'h0004, pc);
    endtask : t_prog
    task automatic t_banks;
        for (int b = 0; b < 4; b++) begin
            wr(7'h03, 8'(b << 5));
            chk("bank", 13'(b), {11'h000, bank});
            wr(7'h20, 8'(8'ha0 + b));
            rd(7'h03, 8'(b << 5));
            rd(7'h01, 8'h00);
        end
        wr(7'h7f, 8'h5c);
        for (int b = 0; b < 4; b++) begin
            wr(7'h03, 8'(b << 5));
            rd(7'h20, 8'(8'ha0 + b));
            rd(7'h7f, 8'h5c);
        end
    endtask : t_banks
    task automatic t_indirect;
        wr(7'h03, 8'h00);
        wr(7'h04, 8'ha1);
        chk("indirect_pointer", 13'h00a1, {5'h00, indirect_pointer});
        wr(7'h00, 8'h5a);
        wr(7'h03, 8'h20);
        pr.fetch_en = 1'b1;
        rd(7'h21, 8'h5a);
        pr.fetch_en = 1'b0;
        chk("pc", 13'h0006, pc);
    endtask : t_indirect
    // Core registers read back from bank 1; a low-byte write loads the counter from the latch
    task automatic t_core;
        wr(7'h0a, 8'h15);
        wr(7'h0b, 8'h80);
        wr(7'h02, 8'h67);
        chk("pc", 13'h1567, pc);
        chk("prog_addr", 13'h0567, prog_addr);
        chk("prog_addr_8k", 13'h1567, prog_addr_8k);
        rd(7'h0a, 8'h15);
        rd(7'h0b, 8'h80);
        rd(7'h02, 8'h67);
        rd(7'h04, 8'ha1);
    endtask : t_core
    // Reset in mid-run returns counter, status and bank select to their reset values
    task automatic t_rereset;
        rstn = 1'b0;
        @(negedge clk_sys);
        chk("prog_valid", 13'h0000, {12'h000, prog_valid});
        chk("pc", 13'h0000, pc);
        rstn = 1'b1;
        @(negedge clk_sys);
        chk("pc", 13'h0000, pc);
        chk("status", 13'h0018, {5'h00, status});
        chk("bank", 13'h0000, {11'h000, bank});
        chk("prog_valid", 13'h0001, {12'h000, prog_valid});
    endtask : t_rereset
    task automatic conclude;
        if (err_count == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : conclude
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (20) @(negedge clk_sys);
        rstn = 1'b1;
        @(negedge clk_sys);
        t_reset();
        t_prog();
        t_banks();
        t_indirect();
        t_core();
        t_rereset();
        conclude();
    end
    initial begin
        #20000;
        err_count++;
        conclude();
    end
endmodule : pmm_map_tb
